//--- inc/ecmd_consts.vh
// constants for the common-mode select and frame mode decode block
`ifndef ECMD_CONSTS_VH
`define ECMD_CONSTS_VH

// ----------------------------------------
// register indices, byte address is index times four
// ----------------------------------------
`define ECMD_IDX_CHAN_CTRL 6'h01
`define ECMD_IDX_CM_REF_CTRL 6'h05
`define ECMD_IDX_FRAME_CTRL 6'h0a
`define ECMD_IDX_STATUS 6'h0b

// ----------------------------------------
// field positions
// ----------------------------------------
`define ECMD_CHAN_CFG_BIT 10
`define ECMD_FRAME_FMT_BIT 4
`define ECMD_CE_REF_ON_BIT 8
`define ECMD_PWR_ON_BIT 7
`define ECMD_DRIVE_BIT 6
`define ECMD_EXT_CM_BIT 5
`define ECMD_LA_BIT 4
`define ECMD_LL_BIT 3
`define ECMD_RA_BIT 2
`define ECMD_V1_BIT 1
`define ECMD_V2_BIT 0
`define ECMD_STAT_SW_LSB 0
`define ECMD_STAT_MODE_LSB 8
`define ECMD_STAT_VALID_BIT 11
`define ECMD_STAT_ROUTE_LSB 16

// ----------------------------------------
// reset values
// ----------------------------------------
`define ECMD_RST_CM_REF 9'h000
`define ECMD_RST_BIT 1'b0

// ----------------------------------------
// frame modes, code is {format, input config, common electrode}
// ----------------------------------------
`define ECMD_MODE_DIGITAL_LEAD 3'h0
`define ECMD_MODE_CE_A 3'h1
`define ECMD_MODE_ANALOG_LEAD 3'h2
`define ECMD_MODE_SE_ELECTRODE 3'h4
`define ECMD_MODE_CE_B 3'h5

// ----------------------------------------
// word content codes
// ----------------------------------------
`define ECMD_W_NONE 5'h00
`define ECMD_W_LEAD_I 5'h01
`define ECMD_W_LEAD_II 5'h02
`define ECMD_W_LEAD_III 5'h03
`define ECMD_W_V1_VCM 5'h04
`define ECMD_W_V2_VCM 5'h05
`define ECMD_W_V1_WCT 5'h06
`define ECMD_W_V2_WCT 5'h07
`define ECMD_W_V3_CE_PRIME 5'h08
`define ECMD_W_V1_CE_PRIME 5'h09
`define ECMD_W_V2_CE_PRIME 5'h0a
`define ECMD_W_LA_VCM 5'h0b
`define ECMD_W_LL_VCM 5'h0c
`define ECMD_W_RA_VCM 5'h0d
`define ECMD_W_LA_CE 5'h0e
`define ECMD_W_LL_CE 5'h0f
`define ECMD_W_V1_CE 5'h10
`define ECMD_W_V2_CE 5'h11
`define ECMD_W_V3_CE 5'h12

`endif

//--- core/ecmd_word_map.v
// word content map for each frame mode
`timescale 1ns/1ps
`include "ecmd_consts.vh"

module ecmd_word_map
(
	input wire [2:0] mode_i,
	output reg [4:0] word1_o,
	output reg [4:0] word2_o,
	output reg [4:0] word3_o,
	output reg [4:0] word4_o,
	output reg [4:0] word5_o,
	output reg valid_o
);

	always @*
	begin
		word1_o = `ECMD_W_NONE;
		word2_o = `ECMD_W_NONE;
		word3_o = `ECMD_W_NONE;
		word4_o = `ECMD_W_NONE;
		word5_o = `ECMD_W_NONE;
		valid_o = 1'b1;
		case (mode_i)
			`ECMD_MODE_ANALOG_LEAD:
			begin
				word1_o = `ECMD_W_LEAD_I;
				word2_o = `ECMD_W_LEAD_II;
				word3_o = `ECMD_W_LEAD_III;
				word4_o = `ECMD_W_V1_VCM;
				word5_o = `ECMD_W_V2_VCM;
			end
			`ECMD_MODE_DIGITAL_LEAD:
			begin
				word1_o = `ECMD_W_LEAD_I;
				word2_o = `ECMD_W_LEAD_II;
				word3_o = `ECMD_W_LEAD_III;
				word4_o = `ECMD_W_V1_WCT;
				word5_o = `ECMD_W_V2_WCT;
			end
			`ECMD_MODE_CE_A:
			begin
				word1_o = `ECMD_W_LEAD_I;
				word2_o = `ECMD_W_LEAD_II;
				word3_o = `ECMD_W_V3_CE_PRIME;
				word4_o = `ECMD_W_V1_CE_PRIME;
				word5_o = `ECMD_W_V2_CE_PRIME;
			end
			`ECMD_MODE_SE_ELECTRODE:
			begin
				word1_o = `ECMD_W_LA_VCM;
				word2_o = `ECMD_W_LL_VCM;
				word3_o = `ECMD_W_RA_VCM;
				word4_o = `ECMD_W_V1_VCM;
				word5_o = `ECMD_W_V2_VCM;
			end
			`ECMD_MODE_CE_B:
			begin
				word1_o = `ECMD_W_LA_CE;
				word2_o = `ECMD_W_LL_CE;
				word3_o = `ECMD_W_V1_CE;
				word4_o = `ECMD_W_V2_CE;
				word5_o = `ECMD_W_V3_CE;
			end
			default:
			begin
				// combinations with no defined word layout
				valid_o = 1'b0;
			end
		endcase
	end

endmodule

//--- core/ecmd_cm_select.v
// common-mode switch decode, frame mode decode and apb register file
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "ecmd_consts.vh"

module ecmd_cm_select
(
	input wire clock_i,
	input wire nrst_i,
	input wire [7:0] paddr_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [31:0] pwdata_i,
	output wire [31:0] prdata_o,
	output wire pready_o,
	output wire pslverr_o,
	output wire [7:1] cm_switch_o,
	output wire [5:0] drive_route_o,
	output wire cm_output_en_o,
	output wire frame_format_sel_o,
	output wire channel_input_config_o,
	output wire common_electrode_ref_on_o,
	output wire [2:0] frame_mode_o,
	output wire frame_mode_valid_o,
	output wire [4:0] word1_src_o,
	output wire [4:0] word2_src_o,
	output wire [4:0] word3_src_o,
	output wire [4:0] word4_src_o,
	output wire [4:0] word5_src_o
);

	// ----------------------------------------
	// software visible control bits
	// ----------------------------------------
	reg frame_format_sel_q;
	reg channel_input_config_q;
	reg [8:0] cm_ref_ctrl_q;

	wire common_electrode_ref_on;
	wire common_mode_power_on;
	wire cm_drive_out_sel;
	wire external_cm_select;
	wire left_arm_cm_contrib;
	wire left_leg_cm_contrib;
	wire right_arm_cm_contrib;
	wire chest_one_cm_contrib;
	wire chest_two_cm_contrib;

	assign common_electrode_ref_on = cm_ref_ctrl_q[`ECMD_CE_REF_ON_BIT];
	assign common_mode_power_on = cm_ref_ctrl_q[`ECMD_PWR_ON_BIT];
	assign cm_drive_out_sel = cm_ref_ctrl_q[`ECMD_DRIVE_BIT];
	assign external_cm_select = cm_ref_ctrl_q[`ECMD_EXT_CM_BIT];
	assign left_arm_cm_contrib = cm_ref_ctrl_q[`ECMD_LA_BIT];
	assign left_leg_cm_contrib = cm_ref_ctrl_q[`ECMD_LL_BIT];
	assign right_arm_cm_contrib = cm_ref_ctrl_q[`ECMD_RA_BIT];
	assign chest_one_cm_contrib = cm_ref_ctrl_q[`ECMD_V1_BIT];
	assign chest_two_cm_contrib = cm_ref_ctrl_q[`ECMD_V2_BIT];

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire [5:0] reg_idx;
	wire addr_aligned;
	wire hit_chan;
	wire hit_cm_ref;
	wire hit_frame;
	wire hit_status;
	wire addr_mapped;
	wire setup_phase;
	wire access_phase;
	wire wr_en;

	assign reg_idx = paddr_i[7:2];
	assign addr_aligned = (paddr_i[1:0] == 2'h0);
	assign hit_chan = addr_aligned && (reg_idx == `ECMD_IDX_CHAN_CTRL);
	assign hit_cm_ref = addr_aligned && (reg_idx == `ECMD_IDX_CM_REF_CTRL);
	assign hit_frame = addr_aligned && (reg_idx == `ECMD_IDX_FRAME_CTRL);
	assign hit_status = addr_aligned && (reg_idx == `ECMD_IDX_STATUS);
	assign addr_mapped = hit_chan || hit_cm_ref || hit_frame || hit_status;
	assign setup_phase = psel_i && !penable_i;
	assign access_phase = psel_i && penable_i;

	// zero wait states: read data is captured in the setup cycle
	assign pready_o = 1'b1;
	// bad address flags only in the access cycle; its write is dropped
	assign pslverr_o = access_phase && !addr_mapped;
	assign wr_en = access_phase && pwrite_i;

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always @(posedge clock_i)
	begin
		if (!nrst_i)
		begin
			frame_format_sel_q <= `ECMD_RST_BIT;
			channel_input_config_q <= `ECMD_RST_BIT;
			cm_ref_ctrl_q <= `ECMD_RST_CM_REF;
		end
		else if (wr_en)
		begin
			if (hit_frame)
			begin
				frame_format_sel_q <= pwdata_i[`ECMD_FRAME_FMT_BIT];
			end
			if (hit_chan)
			begin
				channel_input_config_q <= pwdata_i[`ECMD_CHAN_CFG_BIT];
			end
			if (hit_cm_ref)
			begin
				cm_ref_ctrl_q <= pwdata_i[8:0];
			end
		end
	end

	// ----------------------------------------
	// common-mode switch decode
	// ----------------------------------------
	reg [7:1] sw_d;
	reg [5:0] route_d;
	reg [4:0] electrode_sw;

	// drive redirect and summing share the contribution bits, one use at a time
	always @*
	begin
		sw_d = 7'h00;
		route_d = 6'h00;
		electrode_sw = 5'h00;
		if (!common_mode_power_on)
		begin
			// everything open and no drive redirect
			sw_d = 7'h00;
			route_d = 6'h00;
		end
		else if (external_cm_select)
		begin
			// electrode bits have no say on the switches here
			sw_d[1] = 1'b1;
			route_d[5] = cm_drive_out_sel;
		end
		else
		begin
			if (!cm_drive_out_sel)
			begin
				electrode_sw[0] = left_arm_cm_contrib;
				electrode_sw[1] = left_leg_cm_contrib;
				electrode_sw[2] = right_arm_cm_contrib;
				electrode_sw[3] = chest_one_cm_contrib;
				electrode_sw[4] = chest_two_cm_contrib;
			end
			else
			begin
				// contribution bits steer the drive instead of the sum
				route_d[0] = left_arm_cm_contrib;
				route_d[1] = left_leg_cm_contrib;
				route_d[2] = right_arm_cm_contrib;
				route_d[3] = chest_one_cm_contrib;
				route_d[4] = chest_two_cm_contrib;
			end
			sw_d[6:2] = electrode_sw;
			// reference only when no electrode contributes, so node never floats
			sw_d[7] = ~(|electrode_sw);
		end
		// reference and external input are mutually exclusive
		if (sw_d[1])
		begin
			sw_d[7] = 1'b0;
		end
	end

	// ----------------------------------------
	// registered switch and route outputs
	// ----------------------------------------
	reg [7:1] cm_switch_q;
	reg [5:0] drive_route_q;
	reg cm_output_en_q;

	always @(posedge clock_i)
	begin
		if (!nrst_i)
		begin
			cm_switch_q <= 7'h00;
			drive_route_q <= 6'h00;
			cm_output_en_q <= 1'b0;
		end
		else
		begin
			cm_switch_q <= sw_d;
			drive_route_q <= route_d;
			cm_output_en_q <= common_mode_power_on;
		end
	end

	assign cm_switch_o = cm_switch_q;
	assign drive_route_o = drive_route_q;
	assign cm_output_en_o = cm_output_en_q;

	// ----------------------------------------
	// frame mode decode
	// ----------------------------------------
	wire [2:0] mode_code;
	wire [4:0] map_w1;
	wire [4:0] map_w2;
	wire [4:0] map_w3;
	wire [4:0] map_w4;
	wire [4:0] map_w5;
	wire map_valid;

	assign mode_code = {frame_format_sel_q, channel_input_config_q,
		common_electrode_ref_on};

	ecmd_word_map u_word_map
	(
		.mode_i(mode_code),
		.word1_o(map_w1),
		.word2_o(map_w2),
		.word3_o(map_w3),
		.word4_o(map_w4),
		.word5_o(map_w5),
		.valid_o(map_valid)
	);

	reg [2:0] frame_mode_q;
	reg frame_mode_valid_q;
	reg [4:0] word1_q;
	reg [4:0] word2_q;
	reg [4:0] word3_q;
	reg [4:0] word4_q;
	reg [4:0] word5_q;
	reg frame_format_out_q;
	reg chan_cfg_out_q;
	reg ce_ref_out_q;

	// codes with no layout give NONE words, so no stale map is shown

	always @(posedge clock_i)
	begin
		if (!nrst_i)
		begin
			frame_mode_q <= `ECMD_MODE_DIGITAL_LEAD;
			frame_mode_valid_q <= 1'b0;
			word1_q <= `ECMD_W_NONE;
			word2_q <= `ECMD_W_NONE;
			word3_q <= `ECMD_W_NONE;
			word4_q <= `ECMD_W_NONE;
			word5_q <= `ECMD_W_NONE;
			frame_format_out_q <= 1'b0;
			chan_cfg_out_q <= 1'b0;
			ce_ref_out_q <= 1'b0;
		end
		else
		begin
			frame_mode_q <= mode_code;
			frame_mode_valid_q <= map_valid;
			word1_q <= map_w1;
			word2_q <= map_w2;
			word3_q <= map_w3;
			word4_q <= map_w4;
			word5_q <= map_w5;
			frame_format_out_q <= frame_format_sel_q;
			chan_cfg_out_q <= channel_input_config_q;
			ce_ref_out_q <= common_electrode_ref_on;
		end
	end

	assign frame_mode_o = frame_mode_q;
	assign frame_mode_valid_o = frame_mode_valid_q;
	assign word1_src_o = word1_q;
	assign word2_src_o = word2_q;
	assign word3_src_o = word3_q;
	assign word4_src_o = word4_q;
	assign word5_src_o = word5_q;
	assign frame_format_sel_o = frame_format_out_q;
	assign channel_input_config_o = chan_cfg_out_q;
	assign common_electrode_ref_on_o = ce_ref_out_q;

	// ----------------------------------------
	// read path
	// ----------------------------------------
	reg [31:0] rdata_d;
	reg [31:0] prdata_q;

	always @*
	begin
		rdata_d = 32'h0000_0000;
		if (hit_chan)
		begin
			rdata_d[`ECMD_CHAN_CFG_BIT] = channel_input_config_q;
		end
		else if (hit_cm_ref)
		begin
			rdata_d[8:0] = cm_ref_ctrl_q;
		end
		else if (hit_frame)
		begin
			rdata_d[`ECMD_FRAME_FMT_BIT] = frame_format_sel_q;
		end
		else if (hit_status)
		begin
			// live switch state shows the block's own decode result
			rdata_d[`ECMD_STAT_SW_LSB +: 7] = cm_switch_q;
			rdata_d[`ECMD_STAT_MODE_LSB +: 3] = frame_mode_q;
			rdata_d[`ECMD_STAT_VALID_BIT] = frame_mode_valid_q;
			rdata_d[`ECMD_STAT_ROUTE_LSB +: 6] = drive_route_q;
		end
	end

	// ----------------------------------------
	// read data register
	// ----------------------------------------
	// status lags a control write by one clock, as the decode is registered
	// sampled at setup so the access cycle can answer at once
	always @(posedge clock_i)
	begin
		if (!nrst_i)
		begin
			prdata_q <= 32'h0000_0000;
		end
		else if (setup_phase && !pwrite_i)
		begin
			prdata_q <= rdata_d;
		end
	end

	assign prdata_o = prdata_q;

endmodule

//--- testbench/ecmd_cm_select_properties.sv
// concurrent checks on the ports of the common-mode select block
`timescale 1ns/1ps
`include "ecmd_consts.vh"

module ecmd_cm_select_properties
(
	input wire clock_i,
	input wire nrst_i,
	input wire [7:0] paddr_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [31:0] pwdata_i,
	input wire pready_o,
	input wire [7:1] cm_switch_o,
	input wire cm_output_en_o,
	input wire frame_format_sel_o,
	input wire channel_input_config_o,
	input wire common_electrode_ref_on_o,
	input wire [2:0] frame_mode_o,
	input wire frame_mode_valid_o,
	input wire [4:0] word1_src_o,
	input wire [4:0] word3_src_o,
	input wire [4:0] word5_src_o
);
default clocking @(posedge clock_i); endclocking
default disable iff (!nrst_i);
// ----------
// named steps
// ----------
sequence s_cm_wr;
	psel_i && penable_i && pwrite_i && pready_o && paddr_i == {`ECMD_IDX_CM_REF_CTRL, 2'b00};
endsequence
sequence s_mode_b_held;
	frame_mode_o == `ECMD_MODE_CE_B && $stable(frame_mode_o);
endsequence
// ----------
// checks
// ----------
AST_PWR_OFF: assert property (!cm_output_en_o |-> cm_switch_o == 7'h00)
	else $error("switch closed while unpowered");
// decode lands one clock after the register, so look two edges on
AST_WR_OFF: assert property (s_cm_wr ##0 !pwdata_i[7] |=> ##1 cm_switch_o == 7'h00)
	else $error("power-off write left a switch closed");
AST_WR_EXT: assert property (s_cm_wr ##0 pwdata_i[7:5] == 3'b101 |=> ##1 cm_switch_o == 7'h01)
	else $error("external select did not close only SW1");
AST_SW1_SW7: assert property (!(cm_switch_o[1] && cm_switch_o[7]))
	else $error("SW1 and SW7 closed together");
AST_NO_FLOAT: assert property (cm_output_en_o && !cm_switch_o[1] |-> |cm_switch_o[7:2])
	else $error("common-mode node floating");
AST_SW7_ALONE: assert property (cm_switch_o[7] |-> cm_switch_o[6:2] == 5'h00)
	else $error("SW7 closed with an electrode switch");
AST_MODE_CODE: assert property (frame_mode_o ==
	{frame_format_sel_o, channel_input_config_o, common_electrode_ref_on_o})
	else $error("mode code differs from control bits");
// valid resets low while the code resets to a valid mode, so skip the first edge
AST_MODE_VALID: assert property ($past(nrst_i)
	|-> frame_mode_valid_o == !(frame_mode_o inside {3, 6, 7}))
	else $error("mode valid flag wrong");
AST_CE_B_WORDS: assert property (s_mode_b_held |-> word1_src_o == `ECMD_W_LA_CE
	&& word3_src_o == `ECMD_W_V1_CE && word5_src_o == `ECMD_W_V3_CE)
	else $error("common electrode words wrong");
AST_PREADY: assert property (psel_i && penable_i |-> pready_o)
	else $error("access not answered");
endmodule

bind ecmd_cm_select ecmd_cm_select_properties u_props (.clock_i, .nrst_i, .paddr_i, .psel_i,
	.penable_i, .pwrite_i, .pwdata_i, .pready_o, .cm_switch_o, .cm_output_en_o,
	.frame_format_sel_o, .channel_input_config_o, .common_electrode_ref_on_o, .frame_mode_o,
	.frame_mode_valid_o, .word1_src_o, .word3_src_o, .word5_src_o);

//--- testbench/ecmd_cm_select_tb.sv
// self-checking bench for the common-mode select block
`timescale 1ns/1ps
`include "ecmd_consts.vh"

module ecmd_cm_select_tb;
logic clock_i = 0, nrst_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
logic [7:0] paddr_i = 0;
logic [31:0] pwdata_i = 0;
wire [31:0] prdata_o;
wire pready_o, pslverr_o, cm_output_en_o, frame_format_sel_o, channel_input_config_o;
wire common_electrode_ref_on_o, frame_mode_valid_o;
wire [7:1] cm_switch_o;
wire [5:0] drive_route_o;
wire [2:0] frame_mode_o;
wire [4:0] word1_src_o, word2_src_o, word3_src_o, word4_src_o, word5_src_o;
int n_fail = 0, checks = 0;
logic [31:0] rd;
logic er;
localparam logic [7:0] A_CH = {`ECMD_IDX_CHAN_CTRL, 2'b00};
localparam logic [7:0] A_CM = {`ECMD_IDX_CM_REF_CTRL, 2'b00};
localparam logic [7:0] A_FR = {`ECMD_IDX_FRAME_CTRL, 2'b00};
localparam logic [7:0] A_ST = {`ECMD_IDX_STATUS, 2'b00};

ecmd_cm_select dut (.clock_i, .nrst_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
	.prdata_o, .pready_o, .pslverr_o, .cm_switch_o, .drive_route_o, .cm_output_en_o,
	.frame_format_sel_o, .channel_input_config_o, .common_electrode_ref_on_o, .frame_mode_o,
	.frame_mode_valid_o, .word1_src_o, .word2_src_o, .word3_src_o, .word4_src_o, .word5_src_o);

always #25 clock_i = ~clock_i;

// ----------
// helpers
// ----------
task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
	checks++;
	if (s !== x)
	begin
		n_fail++;
		$display("[ERR] %s expected %h seen %h", nm, x, s);
	end
endtask

// one spare edge after release keeps psel from being assigned twice in a step
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
	int n;
	n = 0;
	psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
	@(posedge clock_i);
	penable_i <= 1;
	@(posedge clock_i);
	while (pready_o !== 1'b1 && n < 50)
	begin
		@(posedge clock_i);
		n++;
	end
	if (pready_o !== 1'b1)
	begin
		n_fail++;
		$display("[ERR] pready expected 1 seen %b", pready_o);
	end
	rd = prdata_o;
	er = pslverr_o;
	psel_i <= 0; penable_i <= 0;
	@(posedge clock_i);
endtask

// decode outputs move one edge after the write; look at them mid-cycle
task settle;
	@(negedge clock_i);
endtask

task stop_test;
	$display("checks %0d n_fail %0d", checks, n_fail);
	if (n_fail == 0 && checks > 0)
		$display("SIMULATION PASSED");
	else
		$display("SIMULATION FAILED");
	$finish;
endtask

function automatic logic [24:0] ew(input logic [2:0] m);
	case (m)
	3'h0: ew = {`ECMD_W_LEAD_I, `ECMD_W_LEAD_II, `ECMD_W_LEAD_III, `ECMD_W_V1_WCT, `ECMD_W_V2_WCT};
	3'h1: ew = {`ECMD_W_LEAD_I, `ECMD_W_LEAD_II, `ECMD_W_V3_CE_PRIME, `ECMD_W_V1_CE_PRIME,
		`ECMD_W_V2_CE_PRIME};
	3'h2: ew = {`ECMD_W_LEAD_I, `ECMD_W_LEAD_II, `ECMD_W_LEAD_III, `ECMD_W_V1_VCM, `ECMD_W_V2_VCM};
	3'h4: ew = {`ECMD_W_LA_VCM, `ECMD_W_LL_VCM, `ECMD_W_RA_VCM, `ECMD_W_V1_VCM, `ECMD_W_V2_VCM};
	3'h5: ew = {`ECMD_W_LA_CE, `ECMD_W_LL_CE, `ECMD_W_V1_CE, `ECMD_W_V2_CE, `ECMD_W_V3_CE};
	default: ew = 25'h0;
	endcase
endfunction

// ----------
// scenarios
// ----------
task t_switches;
	static logic [8:0] cv[12] = '{9'h000, 9'h07f, 9'h080, 9'h090, 9'h098, 9'h09c,
		9'h082, 9'h081, 9'h0bf, 9'h0df, 9'h0d8, 9'h0e0};
	static logic [6:0] sv[12] = '{7'h00, 7'h00, 7'h40, 7'h02, 7'h06, 7'h0e, 7'h10,
		7'h20, 7'h01, 7'h40, 7'h40, 7'h01};
	static logic [5:0] rv[12] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 6'h1f, 6'h03, 6'h20};
	for (int i = 0; i < 12; i++)
	begin
		apb(1, A_CM, {23'h0, cv[i]});
		settle();
		chk("cm_switch", cm_switch_o, sv[i]);
		chk("cm_en", cm_output_en_o, cv[i][7]);
		chk("drive_route", drive_route_o, rv[i]);
		@(posedge clock_i);
		apb(0, A_ST, 0);
		chk("status_sw", rd[6:0], sv[i]);
		chk("status_route", rd[21:16], rv[i]);
	end
	$display("switch test done");
endtask

task t_modes;
	for (int m = 0; m < 8; m++)
	begin
		apb(1, A_FR, {27'h0, m[2], 4'h0});
		apb(1, A_CH, {21'h0, m[1], 10'h0});
		apb(1, A_CM, {23'h0, m[0], 8'h80});
		settle();
		chk("mode", frame_mode_o, m[2:0]);
		chk("fmt", frame_format_sel_o, m[2]);
		chk("cfg", channel_input_config_o, m[1]);
		chk("ce", common_electrode_ref_on_o, m[0]);
		chk("valid", frame_mode_valid_o, !(m inside {3, 6, 7}));
		chk("words", {word1_src_o, word2_src_o, word3_src_o, word4_src_o, word5_src_o},
			ew(m[2:0]));
		@(posedge clock_i);
	end
	$display("mode test done");
endtask

task t_bus;
	apb(1, A_CH, 32'hffffffff);
	apb(0, A_CH, 0);
	chk("chan_rd", rd, 32'h400);
	apb(1, A_FR, 32'hffffffff);
	apb(0, A_FR, 0);
	chk("frame_rd", rd, 32'h10);
	apb(0, 8'h3c, 0);
	chk("unmapped_err", er, 1'b1);
	chk("unmapped_rd", rd, 32'h0);
	$display("bus test done");
endtask

initial
begin
	repeat (5) @(posedge clock_i);
	nrst_i <= 1;
	@(posedge clock_i);
	chk("rst_sw", cm_switch_o, 7'h00);
	t_switches();
	t_modes();
	t_bus();
	stop_test();
end

initial
begin
	repeat (5000) @(posedge clock_i);
	n_fail++;
	stop_test();
end
endmodule
